// ==== src/art_timer.sv ====
`timescale 1ns/1ps
module art_timer
    import art_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       ext_osc,
    input  wire logic [3:0] sfr_page,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_bit_wr,
    input  wire logic [2:0] sfr_bit_sel,
    input  wire logic       sfr_bit_val,
    input  wire logic       timer_irq_en,
    input  wire logic       high_byte_system_clk_sel,
    input  wire logic       low_byte_system_clk_sel,
    output logic      [7:0] sfr_rdata,
    output logic            irq_req,
    output logic            high_ovf_pulse,
    output logic            low_ovf_pulse
);
    typedef struct packed {
        logic [7:0] control;
        logic [7:0] reload_low_byte;
        logic [7:0] reload_high_byte;
        logic [7:0] count_low_byte;
        logic [7:0] count_high_byte;
        logic [7:0] rdata;
        logic       irq;
        logic       hi_pulse;
        logic       lo_pulse;
    } art_st_t;

    art_st_t s_q;
    art_st_t s_d;

    art_tick_if tk ();

    art_tick_gen u_tick (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .ext_osc (ext_osc),
        .tk      (tk.src)
    );

    logic       page_ok;
    logic       ext_sel_tick;
    logic       lo_tick;
    logic       hi_tick;
    logic       split;
    logic       run;
    logic       lo_wrap;
    logic       hi_wrap;
    logic [7:0] ctl_wr;

    assign page_ok = (sfr_page == ART_SFR_PAGE);
    assign split   = s_q.control[ART_BIT_SPLIT];
    assign run     = s_q.control[ART_BIT_RUN];
    assign ext_sel_tick = s_q.control[ART_BIT_EXT_SEL] ? tk.ext_div_tick
                                                       : tk.sys_div_tick;
    assign lo_tick = low_byte_system_clk_sel ? 1'b1 : ext_sel_tick;
    assign hi_tick = high_byte_system_clk_sel ? 1'b1 : ext_sel_tick;

    always_comb begin
        s_d = s_q;
        s_d.hi_pulse = 1'b0;
        s_d.lo_pulse = 1'b0;
        lo_wrap = 1'b0;
        hi_wrap = 1'b0;
        ctl_wr = s_q.control;
        if (split) begin
            // Low byte ignores run control in split mode
            if (lo_tick) begin
                if (s_q.count_low_byte == 8'hFF) begin
                    lo_wrap = 1'b1;
                    s_d.count_low_byte = s_q.reload_low_byte;
                end else begin
                    s_d.count_low_byte = s_q.count_low_byte + 8'h01;
                end
            end
            if (run && hi_tick) begin
                if (s_q.count_high_byte == 8'hFF) begin
                    hi_wrap = 1'b1;
                    s_d.count_high_byte = s_q.reload_high_byte;
                end else begin
                    s_d.count_high_byte = s_q.count_high_byte + 8'h01;
                end
            end
        end else if (run && lo_tick) begin
            // 16-bit mode steps on the low byte clock select
            if (s_q.count_low_byte == 8'hFF) begin
                lo_wrap = 1'b1;
                if (s_q.count_high_byte == 8'hFF) begin
                    hi_wrap = 1'b1;
                    s_d.count_low_byte = s_q.reload_low_byte;
                    s_d.count_high_byte = s_q.reload_high_byte;
                end else begin
                    s_d.count_low_byte = 8'h00;
                    s_d.count_high_byte = s_q.count_high_byte + 8'h01;
                end
            end else begin
                s_d.count_low_byte = s_q.count_low_byte + 8'h01;
            end
        end

        // Software access; a counter write overrides that cycle's step
        if (sfr_wr && page_ok) begin
            unique case (sfr_addr)
                ART_ADDR_CONTROL:
                    ctl_wr = sfr_wdata & ART_CONTROL_WMASK;
                ART_ADDR_RELOAD_LOW:  s_d.reload_low_byte = sfr_wdata;
                ART_ADDR_RELOAD_HIGH: s_d.reload_high_byte = sfr_wdata;
                ART_ADDR_COUNT_LOW:   s_d.count_low_byte = sfr_wdata;
                ART_ADDR_COUNT_HIGH:  s_d.count_high_byte = sfr_wdata;
                default: ;
            endcase
        end else if (sfr_bit_wr && page_ok && sfr_addr == ART_ADDR_CONTROL) begin
            ctl_wr[sfr_bit_sel] = sfr_bit_val;
            ctl_wr = ctl_wr & ART_CONTROL_WMASK;
        end
        // Hardware set wins over a same-cycle software clear
        ctl_wr[ART_BIT_HIGH_FLAG] = ctl_wr[ART_BIT_HIGH_FLAG] | hi_wrap;
        ctl_wr[ART_BIT_LOW_FLAG] = ctl_wr[ART_BIT_LOW_FLAG] | lo_wrap;
        s_d.control = ctl_wr;

        s_d.hi_pulse = hi_wrap;
        s_d.lo_pulse = lo_wrap;
        // Level request follows the sticky flags, so it holds until cleared
        s_d.irq = timer_irq_en &&
                  (ctl_wr[ART_BIT_HIGH_FLAG] ||
                   (ctl_wr[ART_BIT_LOW_IRQ_EN] &&
                    ctl_wr[ART_BIT_LOW_FLAG]));

        s_d.rdata = s_q.rdata;
        if (sfr_rd && page_ok) begin
            unique case (sfr_addr)
                ART_ADDR_CONTROL:     s_d.rdata = s_q.control;
                ART_ADDR_RELOAD_LOW:  s_d.rdata = s_q.reload_low_byte;
                ART_ADDR_RELOAD_HIGH: s_d.rdata = s_q.reload_high_byte;
                ART_ADDR_COUNT_LOW:   s_d.rdata = s_q.count_low_byte;
                ART_ADDR_COUNT_HIGH:  s_d.rdata = s_q.count_high_byte;
                default:              s_d.rdata = ART_RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sfr_rdata      = s_q.rdata;
    assign irq_req        = s_q.irq;
    assign high_ovf_pulse = s_q.hi_pulse;
    assign low_ovf_pulse  = s_q.lo_pulse;
endmodule

// ==== src/art_pkg.sv ====
package art_pkg;
    localparam logic [7:0] ART_ADDR_CONTROL     = 8'hC8;
    localparam logic [7:0] ART_ADDR_RELOAD_LOW  = 8'hCA;
    localparam logic [7:0] ART_ADDR_RELOAD_HIGH = 8'hCB;
    localparam logic [7:0] ART_ADDR_COUNT_LOW   = 8'hCC;
    localparam logic [7:0] ART_ADDR_COUNT_HIGH  = 8'hCD;
    localparam logic [3:0] ART_SFR_PAGE         = 4'hF;
    localparam int ART_BIT_HIGH_FLAG  = 7;
    localparam int ART_BIT_LOW_FLAG   = 6;
    localparam int ART_BIT_LOW_IRQ_EN = 5;
    localparam int ART_BIT_SPLIT      = 3;
    localparam int ART_BIT_RUN        = 2;
    localparam int ART_BIT_EXT_SEL    = 0;
    localparam logic [7:0] ART_CONTROL_WMASK = 8'hED;
    localparam logic [7:0] ART_RESET_BYTE    = 8'h00;
    localparam int ART_SYS_DIV = 12;
    localparam int ART_EXT_DIV = 8;
endpackage

// ==== src/art_tick_if.sv ====
`timescale 1ns/1ps
interface art_tick_if;
    logic sys_div_tick;
    logic ext_div_tick;
    modport src (output sys_div_tick, output ext_div_tick);
    modport dst (input sys_div_tick, input ext_div_tick);
endinterface

// ==== src/art_tick_gen.sv ====
`timescale 1ns/1ps
module art_tick_gen
    import art_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic ext_osc,
    art_tick_if.src   tk
);
    typedef struct packed {
        logic [3:0] sys_cnt;
        logic [2:0] ext_cnt;
        logic       ext_s1;
        logic       ext_s2;
        logic       ext_s3;
        logic       sys_tick;
        logic       ext_tick;
    } art_tg_t;

    art_tg_t s_q;
    art_tg_t s_d;

    // External oscillator is assumed slower than half ref_clk
    always_comb begin
        s_d = s_q;
        s_d.ext_s1 = ext_osc;
        s_d.ext_s2 = s_q.ext_s1;
        s_d.ext_s3 = s_q.ext_s2;
        s_d.sys_tick = 1'b0;
        s_d.ext_tick = 1'b0;
        if (s_q.sys_cnt == 4'(ART_SYS_DIV - 1)) begin
            s_d.sys_cnt = 4'h0;
            s_d.sys_tick = 1'b1;
        end else begin
            s_d.sys_cnt = s_q.sys_cnt + 4'h1;
        end
        if (s_q.ext_s2 && !s_q.ext_s3) begin
            s_d.ext_cnt = s_q.ext_cnt + 3'h1;
            s_d.ext_tick = (s_q.ext_cnt == 3'(ART_EXT_DIV - 1));
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tk.sys_div_tick = s_q.sys_tick;
    assign tk.ext_div_tick = s_q.ext_tick;
endmodule

// ==== testbench/art_timer_props.sv ====
`timescale 1ns/1ps
module art_timer_props
    import art_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       rst_b,
    input wire logic [3:0] sfr_page,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic       sfr_bit_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       timer_irq_en,
    input wire logic [7:0] sfr_rdata,
    input wire logic       irq_req,
    input wire logic       high_ovf_pulse,
    input wire logic       low_ovf_pulse
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    wire logic pf = sfr_page == ART_SFR_PAGE;
    wire logic rc = sfr_rd && pf && sfr_addr == ART_ADDR_CONTROL;
    wire logic rl = pf && sfr_addr == ART_ADDR_RELOAD_LOW;
    wire logic nw = !(sfr_wr || sfr_bit_wr);
    // A gap cycle without writes keeps a newer write from masking the older
    property p_irq_off; !timer_irq_en |=> !irq_req; endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq w/o enable");
    property p_irq_on; high_ovf_pulse && timer_irq_en |-> ##[0:1] irq_req;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("irq missing");
    property p_unmap; sfr_rd && pf && sfr_addr == 8'hC9 |=> sfr_rdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_unused; rc |=> !sfr_rdata[4] && !sfr_rdata[1]; endproperty
    a_unused: assert property (p_unused) else $error("unused bits");
    property p_rl_rw; sfr_wr && rl ##1 nw ##1 sfr_rd && rl
        |=> sfr_rdata == $past(sfr_wdata, 3); endproperty
    a_rl_rw: assert property (p_rl_rw) else $error("reload readback");
    property p_ctl_rw; sfr_wr && pf && sfr_addr == ART_ADDR_CONTROL ##1 nw ##1 rc
        |=> (sfr_rdata & 8'h2D) == ($past(sfr_wdata, 3) & 8'h2D); endproperty
    a_ctl_rw: assert property (p_ctl_rw) else $error("control readback");
    property p_hflag; high_ovf_pulse ##1 rc |=> sfr_rdata[7]; endproperty
    a_hflag: assert property (p_hflag) else $error("high flag lost");
    property p_lflag; low_ovf_pulse ##1 rc |=> sfr_rdata[6]; endproperty
    a_lflag: assert property (p_lflag) else $error("low flag lost");
    c_irq: cover property (irq_req);
    c_high: cover property (high_ovf_pulse);
    c_low: cover property (low_ovf_pulse);
endmodule
bind art_timer art_timer_props art_timer_props_i (.*);

// ==== testbench/art_timer_tb.sv ====
`timescale 1ns/1ps
module art_timer_tb;
    import art_pkg::*;
    logic       ref_clk, rst_b, ext_osc, sfr_wr, sfr_rd, sfr_bit_wr;
    logic       sfr_bit_val, timer_irq_en, hs, ls, irq_req, hp, lp;
    logic [2:0] sfr_bit_sel;
    logic [3:0] pg;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, got, v;
    int         fails, check_count;
    art_timer art_timer_i (.ref_clk, .rst_b, .ext_osc, .sfr_page(pg),
        .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_bit_wr, .sfr_bit_sel,
        .sfr_bit_val, .timer_irq_en, .high_byte_system_clk_sel(hs),
        .low_byte_system_clk_sel(ls), .sfr_rdata, .irq_req, .high_ovf_pulse(hp),
        .low_ovf_pulse(lp));
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Oscillator at a quarter of the clock, inside the sampling limit
    always begin
        repeat (2) @(posedge ref_clk);
        ext_osc <= ~ext_osc;
    end
    task automatic finish_test;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("FAIL %s exp %h got %h", n, e, g);
        end
    endtask
    // Bit write: index in d[2:0], value in d[3]
    task automatic wr(input logic [7:0] a, d, input bit b = 0);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        {sfr_bit_val, sfr_bit_sel} <= d[3:0];
        {sfr_wr, sfr_bit_wr} <= b ? 2'b01 : 2'b10;
        @(posedge ref_clk);
        {sfr_wr, sfr_bit_wr} <= 2'b00;
    endtask
    task automatic wrs(input logic [15:0] q[$]);
        foreach (q[i]) wr(q[i][15:8], q[i][7:0]);
    endtask
    task automatic rd(input logic [7:0] a, e, input bit c = 1);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge ref_clk);
        sfr_rd <= 1'b0;
        @(negedge ref_clk);
        got = sfr_rdata;
        if (c) chk($sformatf("sfr_rdata@%h", a), e, got);
    endtask
    task automatic rng(input logic [7:0] lo, hi);
        rd(8'hCC, 8'h00, 0);
        check_count++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            fails++;
            $display("FAIL count_low_byte exp %0d..%0d got %h", lo, hi, got);
        end
    endtask
    task automatic wt(input bit h);
        for (int i = 0; i < 3000; i++) begin
            @(negedge ref_clk);
            if ((h ? hp : lp) === 1'b1) return;
        end
        fails++;
        $display("FAIL ovf_pulse exp 1 got 0");
        finish_test();
    endtask
    task automatic t_rst;
        logic [7:0] m [6] = '{8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hCC, 8'hCD};
        foreach (m[i]) rd(m[i], 8'h00);
        $display("t_rst done");
    endtask
    task automatic t_reg;
        wrs('{16'hCBA5, 16'hC8FF, 16'hCA5A});
        rd(8'hCA, 8'h5A);
        rd(8'hCB, 8'hA5);
        rd(8'hC8, 8'hED);
        wr(8'hC8, 8'h07, 1);
        rd(8'hC8, 8'h6D);
        wrs('{16'hC800});
        // A write on another page must not land
        pg <= 4'h0;
        wrs('{16'hCA11});
        pg <= ART_SFR_PAGE;
        rd(8'hCA, 8'h5A);
        $display("t_reg done");
    endtask
    task automatic t_16;
        wrs('{16'hCB80, 16'hCA00, 16'hCDFF, 16'hCCFD, 16'hC804});
        wt(1);
        rd(8'hC8, 8'hC4);
        chk("irq_req", 8'h01, {7'h0, irq_req});
        wrs('{16'hC800});
        rd(8'hC8, 8'h00);
        rd(8'hCD, 8'h80);
        rd(8'hCC, 8'h00, 0);
        v = got;
        rd(8'hCC, v);
        chk("irq_req", 8'h00, {7'h0, irq_req});
        wrs('{16'hCD00, 16'hCCF0, 16'hC824});
        wt(0);
        rd(8'hC8, 8'h64);
        chk("irq_req", 8'h01, {7'h0, irq_req});
        wrs('{16'hC800});
        $display("t_16 done");
    endtask
    task automatic t_split;
        wrs('{16'hCAFE, 16'hCB40, 16'hCCFE, 16'hCDFE, 16'hC808});
        wt(0);
        rd(8'hCD, 8'hFE);
        rd(8'hC8, 8'h48);
        chk("irq_req", 8'h00, {7'h0, irq_req});
        wr(8'hC8, 8'h0D, 1);
        rd(8'hC8, 8'h68);
        chk("irq_req", 8'h01, {7'h0, irq_req});
        wr(8'hC8, 8'h0A, 1);
        wt(1);
        // Reload to 0x40, then one system_clk tick lands before the read
        rd(8'hCD, 8'h41);
        wrs('{16'hC800});
        $display("t_split done");
    endtask
    task automatic t_div;
        wrs('{16'hCD00, 16'hCC00, 16'hC804});
        repeat (240) @(posedge ref_clk);
        wrs('{16'hC800});
        rng(8'd19, 8'd21);
        wrs('{16'hCC00, 16'hC805});
        repeat (320) @(posedge ref_clk);
        wrs('{16'hC801});
        rng(8'd9, 8'd11);
        $display("t_div done");
    endtask
    initial begin
        {rst_b, ext_osc, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val} = '0;
        {sfr_bit_sel, sfr_addr, sfr_wdata, timer_irq_en, hs, ls} = '0;
        pg = ART_SFR_PAGE;
        fails = 0;
        check_count = 0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_rst;
        t_reg;
        timer_irq_en <= 1'b1;
        ls <= 1'b1;
        hs <= 1'b1;
        t_16;
        t_split;
        ls <= 1'b0;
        hs <= 1'b0;
        t_div;
        finish_test;
    end
endmodule
